// ---- common/completion_defines.vh ----
// Register map, field positions and reset values of the completion-signalling block.
`ifndef COMPLETION_DEFINES_VH
`define COMPLETION_DEFINES_VH

// Byte offsets of the register words.
`define OFS_SETTINGS 8'h00
`define OFS_DESC_LAST 8'h1C
`define OFS_CHAIN_FLAGS 8'h20
`define OFS_IRQ_PENDING 8'h24
`define OFS_IRQ_ENABLE 8'h28
`define OFS_FIRE_COUNT 8'h2C

// Settings word fields.
`define TAG_HI 27
`define TAG_LO 24
`define MID_CHAIN_BIT 23
`define FINAL_CHAIN_BIT 22
`define MID_IRQ_BIT 21
`define FINAL_IRQ_BIT 20
`define CODE_HI 17
`define CODE_LO 12
`define CODE_RSVD_BIT 17
`define CPS_BIT 11

// Bits of the settings word that software may store.
`define SETTINGS_WR_MASK 32'h00FB_FF0F

// Reset values and other constants.
`define ZERO32 32'h0000_0000
`define ZERO4 4'h0
`define ONE32 32'h0000_0001
`define FLAG_WIDTH 32

`endif

// ---- hw/completion_flag_bank.v ----
// Bank of 32 sticky flags, set by hardware and cleared by software.
`timescale 1ns/10ps
`include "completion_defines.vh"

module completion_flag_bank (
	input wire hclk,
	input wire hresetn,
	input wire [31:0] set_vec,
	input wire [31:0] clr_vec,
	output wire [31:0] flags
);

	reg [31:0] flag_reg;

	// Each flag sets on its event and clears on its write-one; a set in the clearing cycle wins.
	genvar i;
	generate
		for (i = 0; i < `FLAG_WIDTH; i = i + 1) begin : g_flag
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					flag_reg[i] <= 1'b0;
				end else if (set_vec[i]) begin
					flag_reg[i] <= 1'b1;
				end else if (clr_vec[i]) begin
					flag_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign flags = flag_reg;

endmodule

// ---- hw/completion_signalling.v ----
// Completion signalling of one DMA channel: settings word, chain-event and interrupt flags, AHB-Lite slave.
`timescale 1ns/10ps
`include "completion_defines.vh"

//////////////////////////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Any write to the channel descriptor loads the writer privilege tag (bits 27:24) with the master's id.
// - With bit 23 set, each non-final job completion sets the chain-event flag named by the completion code.
// - With bit 22 set, the final job completion sets the chain-event flag named by the completion code.
// - With bit 21 set, each non-final job completion sets the pending-interrupt flag named by the code.
// - With bit 20 set, the final job completion sets the pending-interrupt flag named by the code.
// - The interrupt output is driven only by pending flags whose enable-mask bit is one.
// - The 6-bit completion code (bits 17:12) selects the flag; only codes 0 to 1Fh act, higher ones are ignored.
// - Bit 11 picks the completion point: 0 after data moved, 1 when the job is handed to the controller.
//////////////////////////////////////////////////////////////////////////////////////////////////////

module completion_signalling (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	input wire [3:0] master_priv_id,
	input wire job_handed,
	input wire job_handed_final,
	input wire job_moved,
	input wire job_moved_final,
	output reg [31:0] chain_events,
	output reg irq
);

	//////////////////////////////////////////////////////////////////////////////////////////////////
	// Register storage.

	reg [31:0] settings_reg;
	reg [3:0] writer_tag_reg;
	reg [31:0] irq_enable_reg;
	reg [31:0] fire_count_reg;
	reg wr_pend_reg;
	reg rd_pend_reg;
	reg [7:0] addr_reg;
	reg [3:0] wr_priv_reg;
	wire [31:0] chain_flags;
	wire [31:0] irq_flags;

	//////////////////////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite address phase.

	// A transfer is taken when selected, non-idle and the bus is ready.
	wire take = hsel & htrans[1] & hready;

	// Writes complete without wait; reads take one wait state so they always see the latest write.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			wr_priv_reg <= `ZERO4;
		end else begin
			wr_pend_reg <= take & hwrite;
			rd_pend_reg <= take & ~hwrite;
			if (take) begin
				addr_reg <= {haddr[7:2], 2'b00};
				wr_priv_reg <= master_priv_id;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////////////
	// Data phase decode.

	wire wr_settings = wr_pend_reg & (addr_reg == `OFS_SETTINGS);
	wire wr_desc = wr_pend_reg & (addr_reg <= `OFS_DESC_LAST);
	wire wr_chain = wr_pend_reg & (addr_reg == `OFS_CHAIN_FLAGS);
	wire wr_pending = wr_pend_reg & (addr_reg == `OFS_IRQ_PENDING);
	wire wr_enable = wr_pend_reg & (addr_reg == `OFS_IRQ_ENABLE);

	// Settings word: only the storable fields take the written value.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settings_reg <= `ZERO32;
		end else if (wr_settings) begin
			settings_reg <= hwdata & `SETTINGS_WR_MASK;
		end
	end

	// The tag follows the master that wrote any word of the descriptor.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			writer_tag_reg <= `ZERO4;
		end else if (wr_desc) begin
			writer_tag_reg <= wr_priv_reg;
		end
	end

	// Interrupt enable mask.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_enable_reg <= `ZERO32;
		end else if (wr_enable) begin
			irq_enable_reg <= hwdata;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////////////
	// Completion events.

	// The completion point selects which report from the transfer controller counts.
	wire cps = settings_reg[`CPS_BIT];
	wire ev_fire = cps ? job_handed : job_moved;
	wire ev_final = cps ? job_handed_final : job_moved_final;
	wire [5:0] code = settings_reg[`CODE_HI:`CODE_LO];
	wire code_ok = ~settings_reg[`CODE_RSVD_BIT];
	wire [31:0] code_bit = `ONE32 << code[4:0];

	// Chain flags are set by the mid or final enable according to the job's position.
	wire chain_hit = ev_fire & code_ok &
		(ev_final ? settings_reg[`FINAL_CHAIN_BIT] : settings_reg[`MID_CHAIN_BIT]);
	wire irq_hit = ev_fire & code_ok &
		(ev_final ? settings_reg[`FINAL_IRQ_BIT] : settings_reg[`MID_IRQ_BIT]);
	wire [31:0] chain_set = chain_hit ? code_bit : `ZERO32;
	wire [31:0] irq_set = irq_hit ? code_bit : `ZERO32;

	// Chain-event flags, cleared by writing ones.
	completion_flag_bank u_chain_bank (
		.hclk(hclk),
		.hresetn(hresetn),
		.set_vec(chain_set),
		.clr_vec(wr_chain ? hwdata : `ZERO32),
		.flags(chain_flags)
	);

	// Pending-interrupt flags, cleared by writing ones.
	completion_flag_bank u_irq_bank (
		.hclk(hclk),
		.hresetn(hresetn),
		.set_vec(irq_set),
		.clr_vec(wr_pending ? hwdata : `ZERO32),
		.flags(irq_flags)
	);

	// Counts completion points that were acted on, for software diagnostics.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fire_count_reg <= `ZERO32;
		end else if (chain_hit | irq_hit) begin
			fire_count_reg <= fire_count_reg + `ONE32;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	// Interrupt and chain events leave through flip-flops.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
			chain_events <= `ZERO32;
		end else begin
			irq <= |(irq_flags & irq_enable_reg);
			chain_events <= chain_flags;
		end
	end

	// Read mux; the descriptor words past the settings word and unmapped offsets read zero.
	reg [31:0] rd_value;
	always @* begin
		rd_value = `ZERO32;
		case (addr_reg)
			`OFS_SETTINGS: begin
				rd_value = settings_reg;
				rd_value[`TAG_HI:`TAG_LO] = writer_tag_reg;
			end
			`OFS_CHAIN_FLAGS: begin
				rd_value = chain_flags;
			end
			`OFS_IRQ_PENDING: begin
				rd_value = irq_flags;
			end
			`OFS_IRQ_ENABLE: begin
				rd_value = irq_enable_reg;
			end
			`OFS_FIRE_COUNT: begin
				rd_value = fire_count_reg;
			end
			default: begin
				rd_value = `ZERO32;
			end
		endcase
	end

	// Bus answer: one wait cycle on reads, data lands as ready returns; response is always OKAY.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= `ZERO32;
		end else begin
			hresp <= 1'b0;
			if (take & ~hwrite) begin
				hreadyout <= 1'b0;
			end else begin
				hreadyout <= 1'b1;
			end
			if (rd_pend_reg) begin
				hrdata <= rd_value;
			end
		end
	end

	// Transfer size is unused: only whole-word accesses are supported.
	wire unused_size = |hsize;

endmodule

// ---- sim/completion_signalling_chk.sv ----
// Port assertions of the completion-signalling block.
`timescale 1ns/10ps
module completion_chk (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire [3:0] master_priv_id,
	input wire job_handed,
	input wire job_handed_final,
	input wire job_moved,
	input wire job_moved_final,
	input wire [31:0] chain_events,
	input wire irq
);
	// Accepted reads, writes and completion pulses.
	wire rd = hsel & htrans[1] & hready & !hwrite;
	wire wr = hsel & htrans[1] & hready & hwrite;
	wire job = job_handed | job_moved;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	chk_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	chk_read_wait: assert property (rd |=> one_wait) else $error("read wait wrong");
	chk_write_nowait: assert property (wr |=> hreadyout) else $error("write stalled");
	chk_rdata_hold: assert property (!$stable(hrdata) |-> $past(rd) || $past(rd, 2)) else $error("read data moved");
	chk_chain_rise: assert property ((chain_events & ~$past(chain_events)) != 32'h0000_0000 |-> $past(job, 2))
		else $error("chain flag set without a job");
	chk_chain_sticky: assert property ((~chain_events & $past(chain_events)) != 32'h0000_0000 |-> $past(wr, 3))
		else $error("chain flag lost");
	chk_irq_rise: assert property ($rose(irq) |-> $past(job, 2) || $past(wr, 3)) else $error("irq rose alone");
	chk_irq_fall: assert property ($fell(irq) |-> $past(wr, 3)) else $error("irq fell alone");
endmodule

bind completion_signalling completion_chk u_completion_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .master_priv_id(master_priv_id),
	.job_handed(job_handed), .job_handed_final(job_handed_final), .job_moved(job_moved),
	.job_moved_final(job_moved_final), .chain_events(chain_events), .irq(irq));

// ---- sim/job_source.sv ----
// Model of the transfer controller reporting handed and moved jobs.
`timescale 1ns/10ps
module job_source (
	input wire hclk,
	input wire hresetn,
	input wire start,
	input wire fin,
	input wire [3:0] lag,
	output reg job_handed,
	output reg job_handed_final,
	output reg job_moved,
	output reg job_moved_final
);
	reg [4:0] cnt_reg;
	reg fin_reg;
	// A job is handed at once and its data finish lag plus one cycles later; idle qualifiers toggle.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 5'h00;
			fin_reg <= 1'b0;
			job_handed <= 1'b0;
			job_handed_final <= 1'b0;
			job_moved <= 1'b0;
			job_moved_final <= 1'b0;
		end else begin
			job_handed <= start;
			job_handed_final <= start ? fin : ~job_handed_final;
			job_moved <= (cnt_reg == 5'h01);
			job_moved_final <= (cnt_reg == 5'h01) ? fin_reg : ~job_moved_final;
			fin_reg <= start ? fin : fin_reg;
			if (start) begin
				cnt_reg <= {1'b0, lag} + 5'h01;
			end else if (cnt_reg != 5'h00) begin
				cnt_reg <= cnt_reg - 5'h01;
			end
		end
	end
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench of the completion-signalling block.
`timescale 1ns/10ps
module tb_top;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0000_0000;
	reg [1:0] htrans = 2'b00;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0000_0000;
	reg [3:0] pid = 4'h0;
	reg start = 1'b0;
	reg fin = 1'b0;
	reg rdy_n = 1'b1;
	reg [31:0] rd_n, q, x, s, m, ce, ip, fc;
	wire hreadyout, hresp, irq, jh, jhf, jm, jmf;
	wire [31:0] hrdata, chain_events;
	integer failures = 0, num_checks = 0, cyc = 0, i;
	always #12.5 hclk = ~hclk;
	// Mid-cycle copies hold what the next rising edge samples.
	always @(negedge hclk) begin
		rdy_n = hreadyout;
		rd_n = hrdata;
	end
	completion_signalling u_completion_signalling (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .master_priv_id(pid), .job_handed(jh),
		.job_handed_final(jhf), .job_moved(jm), .job_moved_final(jmf), .chain_events(chain_events), .irq(irq));
	job_source u_job_source (.hclk(hclk), .hresetn(hresetn), .start(start), .fin(fin), .lag(4'h8),
		.job_handed(jh), .job_handed_final(jhf), .job_moved(jm), .job_moved_final(jmf));
	////////////////////////////////////////////////////////////////////////////////
	function [31:0] xs(input [31:0] v);
		xs = v ^ (v << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	// Flag expected from a settings word, the final qualifier and the two enable bits.
	function [31:0] flag_exp(input [31:0] st, input f, input integer mid, input integer fn);
		flag_exp = (!st[17] && st[f ? fn : mid]) ? (32'h0000_0001 << st[16:12]) : 32'h0000_0000;
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input w, input [31:0] a, input [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (rdy_n !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (rdy_n !== 1'b1);
		q = rd_n;
	endtask
	task results;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Cuts a hung run short.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			results;
		end
	end
	initial begin
		x = 32'h35c0;
		fc = 32'h0000_0000;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 6; i = i + 1) begin
			bus(1'b0, i ? 32'h1C + 4 * i : 0, 0);
			chk(q, 32'h0000_0000);
		end
		$display("test reset done");
		for (i = 0; i < 6; i = i + 1) begin
			x = xs(x);
			s = x & ~32'h0008_0000;
			pid <= x[7:4];
			bus(1'b1, 32'h0, s);
			bus(1'b0, 32'h0, 0);
			chk(q, (s & 32'h00FB_FF0F) | {4'h0, x[7:4], 24'h0});
			pid <= x[11:8];
			bus(1'b1, 32'h1C, x);
			bus(1'b0, 32'h0, 0);
			chk(q & 32'h0F00_0000, {4'h0, x[11:8], 24'h0});
		end
		$display("test settings done");
		for (i = 0; i < 16; i = i + 1) begin
			x = xs(x);
			// The first round always uses a reserved code as a hand-written corner case.
			s = {8'h00, x[3:0], 2'b00, (x[9] & x[11]) | (i == 0), x[8:4], x[10], 11'h000};
			m = xs(x);
			bus(1'b1, 32'h28, m);
			bus(1'b1, 32'h20, 32'hFFFF_FFFF);
			bus(1'b1, 32'h24, 32'hFFFF_FFFF);
			bus(1'b1, 32'h0, s);
			@(posedge hclk);
			start <= 1'b1;
			fin <= x[12];
			@(posedge hclk);
			start <= 1'b0;
			ce = flag_exp(s, x[12], 23, 22);
			ip = flag_exp(s, x[12], 21, 20);
			// A completion point counts once when it sets any flag.
			if ((ce | ip) != 32'h0000_0000) fc = fc + 32'h0000_0001;
			repeat (3) @(posedge hclk);
			#1;
			chk(chain_events, s[11] ? ce : 0);
			repeat (12) @(posedge hclk);
			#1;
			chk(chain_events, ce);
			chk({31'h0, irq}, {31'h0, |(ip & m)});
			bus(1'b0, 32'h24, 0);
			chk(q, ip);
			bus(1'b1, 32'h28, 0);
			repeat (3) @(posedge hclk);
			#1;
			chk({31'h0, irq}, 32'h0000_0000);
		end
		bus(1'b0, 32'h2C, 0);
		chk(q, fc);
		$display("test jobs done");
		results;
	end
endmodule
